// ### bench/gated_timer_checker.sv
/* Port assertions for gated_timer.
   Assumes one clock mclk and reset rst_n. */
`timescale 1ns/1ps
`default_nettype none
module gated_timer_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic crystal_input_pin,
  input wire logic crystal_output_pin,
  input wire logic crystal_osc_run,
  input wire logic sleep_mode,
  input wire logic irq,
  input wire logic wake_request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Read data and register readback
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_hole_read: assert property ($past(reg_rd && reg_addr > 3'h5) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_low_write: assert property (reg_wr && reg_addr == 3'h0 ##1 reg_rd && reg_addr == 3'h0 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("low byte write lost");
  a_ctrl_back: assert property (reg_wr && reg_addr == 3'h2 ##1 reg_rd && reg_addr == 3'h2 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control readback wrong");
  a_gate_back: assert property (reg_wr && reg_addr == 3'h3 ##1 reg_rd && reg_addr == 3'h3 |=> reg_rdata == ($past(reg_wdata, 2) & 8'h80))
    else $error("gate readback wrong");
  // Crystal amplifier and enable
  a_osc_run: assert property (reg_wr && reg_addr == 3'h2 |=> crystal_osc_run == $past(reg_wdata[3]))
    else $error("oscillator enable wrong");
  a_osc_amp: assert property (crystal_output_pin == $past(crystal_osc_run && !crystal_input_pin))
    else $error("amplifier output wrong");
  // Interrupt and wake
  a_wake_irq: assert property (wake_request == (irq && sleep_mode))
    else $error("wake request wrong");
  a_mask_off: assert property (reg_wr && reg_addr == 3'h5 && !reg_wdata[0] |=> !irq)
    else $error("masked irq high");
endmodule // gated_timer_checker
bind gated_timer gated_timer_checker chk (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .crystal_input_pin(crystal_input_pin),
  .crystal_output_pin(crystal_output_pin),
  .crystal_osc_run(crystal_osc_run), .sleep_mode(sleep_mode),
  .irq(irq), .wake_request(wake_request));
`default_nettype wire

// ### bench/gated_timer_tb.sv
/* Self-checking bench for gated_timer.
   Assumes the bound checker and pulse_source on the count inputs. */
`timescale 1ns/1ps
`default_nettype none
module gated_timer_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic gate_permit = 1'b1;
  logic sleep_mode = 1'b0;
  logic go = 1'b0;
  logic [1:0] route = 2'h0;
  logic [7:0] q;
  wire [7:0] reg_rdata;
  wire pulse;
  wire irq;
  wire wake;
  int n_mismatch = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  pulse_source ps (.mclk(mclk), .go(go), .pin(pulse));
  gated_timer uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_count_pin(pulse && route == 2'h0),
    .cap_sense_oscillator(pulse && route == 2'h1),
    .crystal_input_pin(pulse && route == 2'h2), .crystal_output_pin(),
    .crystal_osc_run(), .gate_permit(gate_permit),
    .sleep_mode(sleep_mode), .irq(irq), .wake_request(wake));
  // Bus cycles and comparison
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    q = reg_rdata;
    chk(q, exp);
  endtask
  task automatic fire;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask
  // Reset values and unmapped index
  task automatic t_reset;
    for (int a = 0; a < 7; a++) rd(a[2:0], 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
  endtask
  // Both internal sources at each prescale
  task automatic t_prescale;
    logic [7:0] e;
    for (int s = 0; s < 2; s++) for (int p = 0; p < 4; p++) begin
      e = 8'h80 >> (p + 2 * (1 - s));
      wr(3'h0, 8'h00);
      wr(3'h2, {s[1:0], p[1:0], 4'h1});
      repeat (126) @(posedge mclk);
      wr(3'h2, 8'h00);
      repeat (20) @(posedge mclk);
      rd(3'h0, e);
      rd(3'h1, 8'h00);
    end
  endtask
  // Rollover flag, mask, clear and wake
  task automatic t_overflow;
    wr(3'h5, 8'h01);
    wr(3'h1, 8'hFF);
    wr(3'h0, 8'hF0);
    wr(3'h2, 8'h41);
    repeat (30) @(posedge mclk);
    wr(3'h2, 8'h00);
    rd(3'h4, 8'h01);
    rd(3'h1, 8'h00);
    chk({7'h00, irq}, 8'h01);
    @(posedge mclk);
    sleep_mode <= 1'b1;
    @(negedge mclk);
    chk({7'h00, wake}, 8'h01);
    @(posedge mclk);
    sleep_mode <= 1'b0;
    wr(3'h5, 8'h00);
    @(negedge mclk);
    chk({7'h00, irq}, 8'h00);
    wr(3'h5, 8'h01);
    wr(3'h4, 8'h01);
    @(negedge mclk);
    chk({7'h00, irq}, 8'h00);
  endtask
  // External sources, gate, async in Sleep
  task automatic t_external;
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h81);
    fire;
    rd(3'h0, 8'h04);
    wr(3'h3, 8'h80);
    gate_permit <= 1'b0;
    fire;
    rd(3'h0, 8'h04);
    gate_permit <= 1'b1;
    fire;
    rd(3'h0, 8'h08);
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h85);
    sleep_mode <= 1'b1;
    fire;
    sleep_mode <= 1'b0;
    rd(3'h0, 8'h0C);
    route <= 2'h1;
    wr(3'h2, 8'hC1);
    fire;
    rd(3'h0, 8'h10);
    route <= 2'h2;
    wr(3'h2, 8'h88);
    repeat (20) @(posedge mclk);
    wr(3'h2, 8'h89);
    fire;
    rd(3'h0, 8'h14);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_prescale;
    t_overflow;
    t_external;
    print_verdict;
  end
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule // gated_timer_tb
`default_nettype wire

// ### bench/pulse_source.sv
/* Far-side count source: four clean pulses per go request.
   Assumes go is a one-cycle strobe synchronous to mclk. */
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input wire logic mclk,
  input wire logic go,
  output logic pin
);
  initial pin = 1'b0;
  // Four pulses, four cycles high and low
  always @(posedge go) begin
    repeat (4) begin
      repeat (4) @(posedge mclk);
      pin <= 1'b1;
      repeat (4) @(posedge mclk);
      pin <= 1'b0;
    end
  end
endmodule // pulse_source
`default_nettype wire

// ### core/gated_timer.v
/*
  16-bit gated timer/counter with prescaler, source selection,
  synchronized or unsynchronized external counting and an overflow
  interrupt. Assumes all inputs are synchronous to mclk, a byte
  register port with read data one cycle after the read strobe, and
  gate logic outside that supplies the gate permit level.
  The unsynchronized path is one sample of the selected input, so it
  still needs mclk; a true ripple counter would keep running without it.
  A count byte write wins over an increment in the same cycle and
  clears the hidden prescaler, so a fresh start is exact.
  Switching between the two input paths may drop or add one edge.
  The count is not latched across bytes: a carry may fall between the
  low and the high read.
*/
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "gated_timer_map.vh"

module gated_timer (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Count inputs and crystal amplifier
  input wire external_count_pin,
  input wire cap_sense_oscillator,
  input wire crystal_input_pin,
  output reg crystal_output_pin,
  output wire crystal_osc_run,
  // Gate, Sleep and interrupt
  input wire gate_permit,
  input wire sleep_mode,
  output wire irq,
  output wire wake_request
);

  // Counter, control and input path state
  reg [15:0] count;
  reg [7:0] timer_control_register;
  reg gate_enable_bit;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [2:0] prescale;
  reg [1:0] instr_phase;
  reg sync_a;
  reg sync_b;
  reg async_sample;
  reg ext_prev;
  reg armed;

  // Decoded fields and strobes
  wire [1:0] source_select_field;
  wire [1:0] prescale_select_field;
  wire oscillator_enable_bit;
  wire async_select_bit;
  wire run_bit;
  wire wr_low;
  wire wr_high;
  wire count_write;

  // External input path
  wire ext_selected;
  wire ext_raw;
  wire ext_level;
  wire ext_rise;

  // Count qualification
  wire enabled;
  wire frozen;
  reg src_tick;
  reg [2:0] prescale_last;
  wire pre_tick;
  wire inc;
  wire overflow;

  // Control fields
  assign source_select_field =
    timer_control_register[`SRC_SEL_HI:`SRC_SEL_LO];
  assign prescale_select_field =
    timer_control_register[`PRE_SEL_HI:`PRE_SEL_LO];
  assign oscillator_enable_bit =
    timer_control_register[`OSC_EN_BIT];
  assign async_select_bit = timer_control_register[`ASYNC_BIT];
  assign run_bit = timer_control_register[`RUN_BIT];

  // Count byte write strobes
  assign wr_low = reg_wr && (reg_addr == `OFS_COUNT_LOW);
  assign wr_high = reg_wr && (reg_addr == `OFS_COUNT_HIGH);
  assign count_write = wr_low || wr_high;

  // Crystal amplifier kept running regardless of Sleep
  // Amplifier drives the inverse of the input level
  assign crystal_osc_run = oscillator_enable_bit;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_output_pin <= 1'b0;
    end else begin
      crystal_output_pin <= oscillator_enable_bit &
        ~crystal_input_pin;
    end
  end

  // External input mux: pin or crystal, or cap-sense oscillator
  assign ext_selected = source_select_field[1];
  assign ext_raw = (source_select_field == `SRC_CAPSENSE) ?
    cap_sense_oscillator :
    (oscillator_enable_bit ? crystal_input_pin :
     external_count_pin);

  // Two-flop synchronizer for the synchronized path
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= ext_raw;
      sync_b <= sync_a;
    end
  end

  // Single sample for the unsynchronized path
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      async_sample <= 1'b0;
    end else begin
      async_sample <= ext_raw;
    end
  end

  // Path choice; a switch may drop or add one edge
  assign ext_level = async_select_bit ? async_sample :
    sync_b;

  // Rising edge detector on the chosen level
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // Rise seen on the chosen level
  assign ext_rise = ext_level && !ext_prev;

  // Edge arming: a low level must be seen before counting
  // Count write or stop forces a fresh arm
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (count_write || !run_bit) begin
      armed <= 1'b0;
    end else if (!ext_level) begin
      armed <= 1'b1;
    end
  end

  // Instruction clock phase divider
  // Free running from reset; software cannot align it
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_phase <= 2'h0;
    end else if (instr_phase == `INSTR_DIV) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end

  // Run and gate enable
  assign enabled = run_bit &&
    (!gate_enable_bit || gate_permit);

  // Internal and synchronized clocks stop in Sleep
  // Only the unsynchronized external path stays alive
  assign frozen = sleep_mode &&
    !(ext_selected && async_select_bit);

  // Selected source clock event
  always @* begin
    case (source_select_field)
      `SRC_INSTR: src_tick = (instr_phase == `INSTR_DIV);
      `SRC_SYSTEM: src_tick = 1'b1;
      `SRC_PIN: src_tick = ext_rise && armed;
      `SRC_CAPSENSE: src_tick = ext_rise && armed;
      default: src_tick = 1'b0;
    endcase
  end

  // Prescale terminal count for 1, 2, 4 or 8
  always @* begin
    case (prescale_select_field)
      2'h0: prescale_last = 3'h0;
      2'h1: prescale_last = 3'h1;
      2'h2: prescale_last = 3'h3;
      2'h3: prescale_last = 3'h7;
      default: prescale_last = 3'h0;
    endcase
  end

  // Prescaler terminal reached on a qualified tick
  assign pre_tick = src_tick && enabled && !frozen &&
    (prescale == prescale_last);

  // Hidden prescale counter
  // Cleared by a count write so a new start is exact
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 3'h0;
    end else if (count_write) begin
      prescale <= 3'h0;
    end else if (src_tick && enabled && !frozen) begin
      if (prescale >= prescale_last) begin
        prescale <= 3'h0;
      end else begin
        prescale <= prescale + 3'h1;
      end
    end
  end

  // Increment unless software writes the count this cycle
  assign inc = pre_tick && !count_write;
  assign overflow = inc && (count == 16'hFFFF);

  // The 16-bit count
  // A byte write wins over an increment in the same cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `COUNT_RST;
    end else if (wr_low) begin
      count[7:0] <= reg_wdata;
    end else if (wr_high) begin
      count[15:8] <= reg_wdata;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  // Control registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_register <= `TIMER_CTRL_RST;
      gate_enable_bit <= 1'b0;
      irq_mask <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_TIMER_CTRL: timer_control_register <= reg_wdata;
        `OFS_GATE_CTRL: gate_enable_bit <=
          reg_wdata[`GATE_EN_BIT];
        `OFS_IRQ_MASK: irq_mask <= {7'h00, reg_wdata[`OVF_BIT]};
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // Sticky overflow flag: write one clears, new event wins
  // Only the overflow bit exists; the others stay zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 8'h00;
    end else if (overflow) begin
      irq_status[`OVF_BIT] <= 1'b1;
    end else if (reg_wr && reg_addr == `OFS_IRQ_STATUS &&
                 reg_wdata[`OVF_BIT]) begin
      irq_status[`OVF_BIT] <= 1'b0;
    end
  end

  // Interrupt level and wake from Sleep
  assign irq = |(irq_status & irq_mask);
  assign wake_request = irq && sleep_mode;

  // Read data one cycle after the strobe
  // Idle read data is zero so several slaves can be ORed
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_COUNT_LOW: reg_rdata <= count[7:0];
        `OFS_COUNT_HIGH: reg_rdata <= count[15:8];
        `OFS_TIMER_CTRL: reg_rdata <= timer_control_register;
        `OFS_GATE_CTRL: reg_rdata <= {gate_enable_bit, 7'h00};
        `OFS_IRQ_STATUS: reg_rdata <= irq_status;
        `OFS_IRQ_MASK: reg_rdata <= irq_mask;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // gated_timer

`default_nettype wire

// ### pkg/gated_timer_map.vh
/*
  Constants for the 16-bit gated timer core: register offsets, field
  positions, reset values and clock division counts.
  Assumes a byte-wide register port and one 100 MHz system clock.
*/
// Functional notes
// - 16-bit up counter, byte writes replace count
// - Internal sources count instruction or system cycles, prescaled
// - External source counts selected edges, prescaled
// - Run bit off stops; gate enable gates counting
// - Source select: instr, system, pin/crystal, cap-sense
// - External sources count on rising edge
// - External source synchronized or counted unsynchronized
// - Falling edge required before first counted rise
// - Prescaler divides by 1, 2, 4 or 8
// - Prescaler hidden, cleared on count byte write
// - Oscillator enable starts crystal, runs in Sleep
// - Async select bypasses the synchronizer
// - Async external counting continues in Sleep, wakes
// - Mode switch may drop or add one count
// - Rollover FFFF to 0000 sets overflow flag
`ifndef GATED_TIMER_MAP_VH
`define GATED_TIMER_MAP_VH

// Register offsets
`define OFS_COUNT_LOW 3'h0
`define OFS_COUNT_HIGH 3'h1
`define OFS_TIMER_CTRL 3'h2
`define OFS_GATE_CTRL 3'h3
`define OFS_IRQ_STATUS 3'h4
`define OFS_IRQ_MASK 3'h5

// Timer control fields
`define SRC_SEL_HI 7
`define SRC_SEL_LO 6
`define PRE_SEL_HI 5
`define PRE_SEL_LO 4
`define OSC_EN_BIT 3
`define ASYNC_BIT 2
`define RUN_BIT 0

// Gate control and interrupt fields
`define GATE_EN_BIT 7
`define OVF_BIT 0

// Source select codes
`define SRC_INSTR 2'h0
`define SRC_SYSTEM 2'h1
`define SRC_PIN 2'h2
`define SRC_CAPSENSE 2'h3

// Reset values
`define TIMER_CTRL_RST 8'h00
`define GATE_CTRL_RST 8'h00
`define COUNT_RST 16'h0000

// Last phase of the four system clocks per instruction cycle
`define INSTR_DIV 2'h3

`endif
